// File: flash_host_map.svh
// Constants for the parallel flash host controller: widths, field positions
// and bus-cycle timing. Definitions only; included by the package and RTL.
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// Pin widths and timer counter width
`define ADDR_W            23
`define DATA_W            8
`define CNT_W             8

// Sector field of the byte address
`define SECT_HI           22
`define SECT_LO           16
`define SECT_W            7

// Clock period and interval figures in ns (plain defaults)
`define CLK_NS            10
`define ACCESS_NS         100
`define WR_PULSE_NS       50
`define INIT_PULSE_NS     500
`define INIT_RECOVERY_NS  50

// Least times round up to whole cycles
`define ACCESS_CYC        ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_PULSE_CYC      ((`WR_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_PULSE_CYC    ((`INIT_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_REC_CYC      ((`INIT_RECOVERY_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: flash_host_pkg.sv
// Types shared by the flash host controller and its cycle timer.
// Assumes flash_host_map.svh is on the include path.
package flash_host_pkg;
	`include "flash_host_map.svh"

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_PROG2 = 2'h2,
		OP_RESET = 2'h3
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_RD       = 3'h1,
		ST_WR_PULSE = 3'h2,
		ST_WR_GAP   = 3'h3,
		ST_RST_LOW  = 3'h4,
		ST_RST_REC  = 3'h5,
		ST_RST_WAIT = 3'h6
	} state_t;
endpackage

// File: cycle_timer_if.sv
// Start/done handshake between the sequencer and its interval timer.
// Assumes both ends share clk.
`timescale 1ns/1ps
`include "flash_host_map.svh"
interface cycle_timer_if;
	import flash_host_pkg::*;
	logic               start;
	logic [`CNT_W-1:0]  load;
	logic               done;
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface

// File: cycle_timer.sv
// Down-counting interval timer for bus-cycle phases.
// Assumes start is a one-cycle pulse and load is at least 1.
`timescale 1ns/1ps
`include "flash_host_map.svh"
module cycle_timer
	import flash_host_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rstn,
	cycle_timer_if.tmr  tm
);
	logic [`CNT_W-1:0] cnt_r;

	////////////////////////////////////////////////////////////////////////
	// Count down; done fires on the same edge that the count reaches zero, so the
	// phase lasts at least load cycles.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r   <= 8'h00;
			tm.done <= 1'b0;
		end else begin
			tm.done <= (cnt_r == 8'h01) && !tm.start;
			if (tm.start) begin
				cnt_r <= tm.load;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule

// File: flash_host.sv
// Host controller driving an asynchronous byte-wide parallel NOR flash
// through its pins: reads, single command writes, two-cycle bypass program
// (optionally accelerated) and hardware reset pulses.
// Assumes flash pins are sampled synchronously to clk; tristate resolution
// of data_io is done outside from data_io_oe.
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host
	import flash_host_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rstn,
	// User command port
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire op_t                cmd_op,
	input  wire logic [`ADDR_W-1:0] cmd_addr,
	input  wire logic [`DATA_W-1:0] cmd_wdata,
	input  wire logic [`DATA_W-1:0] cmd_prefix,
	input  wire logic               cmd_accel,
	output logic [`DATA_W-1:0]      rdata,
	output logic                    rdata_valid,
	output logic [`SECT_W-1:0]      sector_select_bits,
	output logic                    op_aborted,
	// Flash pins
	output logic [`ADDR_W-1:0]      flash_addr,
	output logic                    chip_sel_n,
	output logic                    out_gate_n,
	output logic                    wr_strobe_n,
	output logic                    init_n,
	output logic                    speedup_high_level,
	input  wire logic [`DATA_W-1:0] data_io_in,
	output logic [`DATA_W-1:0]      data_io_out,
	output logic                    data_io_oe,
	input  wire logic               ready_busy_out
);
	state_t              state_r;
	logic                second_r;
	logic [`DATA_W-1:0]  hold_r;

	cycle_timer_if tm ();

	cycle_timer u_timer (
		.clk  (clk),
		.rstn (rstn),
		.tm   (tm)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus sequencer: every pin comes from a flop updated here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r            <= ST_IDLE;
			cmd_ready          <= 1'b1;
			second_r           <= 1'b0;
			hold_r             <= 8'h00;
			rdata              <= 8'h00;
			rdata_valid        <= 1'b0;
			flash_addr         <= 23'h000000;
			chip_sel_n         <= 1'b1;
			out_gate_n         <= 1'b1;
			wr_strobe_n        <= 1'b1;
			init_n             <= 1'b1;
			speedup_high_level <= 1'b0;
			data_io_out        <= 8'h00;
			data_io_oe         <= 1'b0;
			tm.start           <= 1'b0;
			tm.load            <= 8'h01;
		end else begin
			tm.start    <= 1'b0;
			rdata_valid <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					cmd_ready  <= 1'b0;
					flash_addr <= cmd_addr;
					tm.start   <= 1'b1;
					case (cmd_op)
					OP_READ: begin
						chip_sel_n <= 1'b0;
						out_gate_n <= 1'b0;
						tm.load    <= 8'(`ACCESS_CYC);
						state_r    <= ST_RD;
					end
					OP_WRITE: begin
						data_io_out <= cmd_wdata;
						data_io_oe  <= 1'b1;
						chip_sel_n  <= 1'b0;
						wr_strobe_n <= 1'b0;
						second_r    <= 1'b0;
						tm.load     <= 8'(`WR_PULSE_CYC);
						state_r     <= ST_WR_PULSE;
					end
					OP_PROG2: begin
						// First of exactly two cycles, then the byte
						data_io_out        <= cmd_prefix;
						hold_r             <= cmd_wdata;
						second_r           <= 1'b1;
						speedup_high_level <= cmd_accel;
						data_io_oe         <= 1'b1;
						chip_sel_n         <= 1'b0;
						wr_strobe_n        <= 1'b0;
						tm.load            <= 8'(`WR_PULSE_CYC);
						state_r            <= ST_WR_PULSE;
					end
					default: begin
						init_n  <= 1'b0;
						tm.load <= 8'(`INIT_PULSE_CYC);
						state_r <= ST_RST_LOW;
					end
					endcase
				end
			end
			ST_RD: begin
				if (tm.done) begin
					rdata       <= data_io_in;
					rdata_valid <= 1'b1;
					chip_sel_n  <= 1'b1;
					out_gate_n  <= 1'b1;
					cmd_ready   <= 1'b1;
					state_r     <= ST_IDLE;
				end
			end
			ST_WR_PULSE: begin
				if (tm.done) begin
					// Data stays driven through the gap for hold time
					wr_strobe_n <= 1'b1;
					tm.start    <= 1'b1;
					tm.load     <= 8'(`WR_PULSE_CYC);
					state_r     <= ST_WR_GAP;
				end
			end
			ST_WR_GAP: begin
				if (tm.done && second_r) begin
					data_io_out <= hold_r;
					second_r    <= 1'b0;
					wr_strobe_n <= 1'b0;
					tm.start    <= 1'b1;
					state_r     <= ST_WR_PULSE;
				end else if (tm.done) begin
					// Speedup level drops with the sequence's end
					chip_sel_n         <= 1'b1;
					data_io_oe         <= 1'b0;
					speedup_high_level <= 1'b0;
					cmd_ready          <= 1'b1;
					state_r            <= ST_IDLE;
				end
			end
			ST_RST_LOW: begin
				if (tm.done) begin
					init_n   <= 1'b1;
					tm.start <= 1'b1;
					tm.load  <= 8'(`INIT_REC_CYC);
					state_r  <= ST_RST_REC;
				end
			end
			ST_RST_REC: begin
				if (tm.done) begin
					state_r <= ST_RST_WAIT;
				end
			end
			ST_RST_WAIT: begin
				// Device busy until its internal reset completes
				if (ready_busy_out) begin
					cmd_ready <= 1'b1;
					state_r   <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reports a reset that cut an embedded operation short, so software
	// knows to reissue it; cleared by the next accepted non-reset command.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_aborted <= 1'b0;
		end else if (state_r == ST_RST_LOW && !ready_busy_out) begin
			op_aborted <= 1'b1;
		end else if (cmd_valid && cmd_ready && cmd_op != OP_RESET) begin
			op_aborted <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sector of the address on the command port (cmd_addr), registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sector_select_bits <= 7'h00;
		end else begin
			sector_select_bits <= cmd_addr[`SECT_HI:`SECT_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks. Helper counters measure reset low time, time since release
	// and write strobes per command.
	logic [9:0] low_cnt_r;
	logic [9:0] since_rel_r;
	logic [1:0] strobes_r;
	logic       we_prev_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt_r   <= 10'h000;
			since_rel_r <= 10'h3FF;
			strobes_r   <= 2'h0;
			we_prev_r   <= 1'b1;
		end else begin
			we_prev_r   <= wr_strobe_n;
			low_cnt_r   <= init_n ? 10'h000 : low_cnt_r + 10'h001;
			if (!init_n) begin
				since_rel_r <= 10'h000;
			end else if (since_rel_r != 10'h3FF) begin
				since_rel_r <= since_rel_r + 10'h001;
			end
			if (cmd_valid && cmd_ready) begin
				strobes_r <= 2'h0;
			end else if (we_prev_r && !wr_strobe_n) begin
				strobes_r <= strobes_r + 2'h1;
			end
		end
	end

	write_levels_a: assert property (@(posedge clk) disable iff (!rstn)
		!wr_strobe_n |-> (!chip_sel_n && out_gate_n && data_io_oe))
		else $error("write strobe low without chip select or with gate low");

	read_levels_a: assert property (@(posedge clk) disable iff (!rstn)
		!out_gate_n |-> (!chip_sel_n && wr_strobe_n))
		else $error("read cycle with bad control levels");

	no_contention_a: assert property (@(posedge clk) disable iff (!rstn)
		!(data_io_oe && !out_gate_n))
		else $error("host drives data while device gate is open");

	speedup_only_a: assert property (@(posedge clk) disable iff (!rstn)
		speedup_high_level |-> !chip_sel_n && out_gate_n)
		else $error("speedup level held outside programming");

	bypass_two_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(speedup_high_level) ##1 (state_r != ST_IDLE) [*1]
		|-> strobes_r <= 2'h2)
		else $error("bypass program used more than two cycles");

	accel_end_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(speedup_high_level) |-> strobes_r == 2'h2)
		else $error("accelerated sequence was not two write cycles");

	reset_width_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(init_n) |-> low_cnt_r >= 10'(`INIT_PULSE_CYC))
		else $error("reset pulse shorter than minimum");

	recovery_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(out_gate_n) |-> since_rel_r >= 10'(`INIT_REC_CYC))
		else $error("read started inside reset recovery");

	read_access_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(out_gate_n) |-> !out_gate_n [*8] ##1 !out_gate_n)
		else $error("read finished before access time");

	busy_wait_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_r == ST_RST_WAIT && !ready_busy_out) |=> !cmd_ready)
		else $error("command accepted while device still busy");

	cover_read_c: cover property (@(posedge clk) disable iff (!rstn)
		rdata_valid);
	cover_accel_c: cover property (@(posedge clk) disable iff (!rstn)
		$fell(speedup_high_level));
	cover_abort_c: cover property (@(posedge clk) disable iff (!rstn)
		$rose(op_aborted));
endmodule

// File: flash_dev_model.sv
// Behavioural model of the byte-wide parallel flash at the far side.
// Assumes pins from flash_host change on clk edges; data_io is resolved here.
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter int BUSY_CYC  = 20,
	parameter int READY_CYC = 90
)(
	input  wire logic               clk,
	input  wire logic [`ADDR_W-1:0] flash_addr,
	input  wire logic               chip_sel_n,
	input  wire logic               out_gate_n,
	input  wire logic               wr_strobe_n,
	input  wire logic               init_n,
	input  wire logic               speedup_high_level,
	input  wire logic [`DATA_W-1:0] data_io_out,
	input  wire logic               data_io_oe,
	output logic [`DATA_W-1:0]      data_io_in,
	output logic                    ready_busy_out,
	output int                      n_wr,
	output int                      n_acc_wr
);
	logic [7:0] mem_r [256];
	logic [7:0] last_r = 8'h00;
	logic       wr_d_r = 1'b1;
	logic       init_d_r = 1'b1;
	int         busy_r = 0;
	logic       drive;
	// Sleep entry: address stable for access time plus 30 ns
	localparam int SLEEP_CYC = `ACCESS_CYC + (30 + `CLK_NS - 1) / `CLK_NS;
	int                 stable_r  = 0;
	logic [`ADDR_W-1:0] addr_d_r  = '0;
	logic [7:0]         sleep_q_r = 8'h00;
	logic               asleep;

	// A write or a new address wakes the array; asleep, data stays latched
	assign asleep = (stable_r >= SLEEP_CYC);

	////////////////////////////////////////
	// Drive only on a selected, gated read; else the host's byte while data_io_oe is high, or the inverse of the last value
	assign drive = !chip_sel_n && !out_gate_n && init_n && wr_strobe_n;
	assign data_io_in = data_io_oe ? data_io_out :
		(drive ? (asleep ? sleep_q_r : mem_r[flash_addr[7:0]]) : ~last_r);
	assign ready_busy_out = (busy_r == 0);

	// Erased array at power-up, read mode by default
	initial begin
		for (int i = 0; i < 256; i++) mem_r[i] = 8'hFF;
		n_wr = 0;
		n_acc_wr = 0;
	end

	// Strobe rise latches data; busy runs on even when deselected
	always @(posedge clk) begin
		wr_d_r <= wr_strobe_n;
		init_d_r <= init_n;
		addr_d_r <= flash_addr;
		if (flash_addr != addr_d_r || (wr_strobe_n && !wr_d_r))
			stable_r <= 0;
		else if (!asleep)
			stable_r <= stable_r + 1;
		if (!asleep)
			sleep_q_r <= mem_r[flash_addr[7:0]];
		if (drive)
			last_r <= mem_r[flash_addr[7:0]];
		if (busy_r > 0)
			busy_r <= busy_r - 1;
		if (!init_n && init_d_r && busy_r > 0)
			busy_r <= READY_CYC;
		if (wr_strobe_n && !wr_d_r && !chip_sel_n && out_gate_n && init_n) begin
			mem_r[flash_addr[7:0]] <= data_io_out;
			n_wr <= n_wr + 1;
			if (speedup_high_level)
				n_acc_wr <= n_acc_wr + 1;
			busy_r <= BUSY_CYC;
		end
	end
endmodule

// File: test_flash_host.sv
// Self-checking bench for flash_host against the flash model.
// Assumes flash_host_map.svh and flash_host_pkg are compiled first.
`timescale 1ns/1ps
`include "flash_host_map.svh"
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_fail++; \
	$display("FAIL %0t %s", $time, m); end end
module test_flash_host;
	import flash_host_pkg::*;
	logic clk = 0, rstn = 0, cmd_valid = 0, cmd_accel = 0;
	op_t  cmd_op = OP_READ;
	logic [`ADDR_W-1:0] cmd_addr = 23'h000000, flash_addr;
	logic [`DATA_W-1:0] cmd_wdata = 8'h00, cmd_prefix = 8'h00, rdata;
	logic [`DATA_W-1:0] data_io_in, data_io_out;
	logic [`SECT_W-1:0] sector_select_bits;
	logic cmd_ready, rdata_valid, op_aborted, chip_sel_n, out_gate_n;
	logic wr_strobe_n, init_n, speedup_high_level, data_io_oe, ready_busy_out;
	int   n_fail = 0, compares = 0, n_wr, n_acc_wr, lat, rv_lat, w0, a0;

	flash_host i_flash_host (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_addr, .cmd_wdata, .cmd_prefix, .cmd_accel, .rdata, .rdata_valid,
		.sector_select_bits, .op_aborted, .flash_addr, .chip_sel_n,
		.out_gate_n, .wr_strobe_n, .init_n, .speedup_high_level, .data_io_in,
		.data_io_out, .data_io_oe, .ready_busy_out);
	flash_dev_model i_flash_dev_model (.clk, .flash_addr, .chip_sel_n,
		.out_gate_n, .wr_strobe_n, .init_n, .speedup_high_level, .data_io_out,
		.data_io_oe, .data_io_in, .ready_busy_out, .n_wr, .n_acc_wr);

	// Free-running clock
	always #5 clk = ~clk;

	////////////////////////////////////////
	// One command: taken at the edge after valid rises, then wait for ready
	task automatic run(input op_t op, input logic [22:0] a,
		input logic [7:0] d, input logic acc);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_prefix <= 8'hA0;
		cmd_accel <= acc;
		@(posedge clk);
		cmd_valid <= 1'b0;
		lat = 0;
		rv_lat = 0;
		w0 = n_wr;
		a0 = n_acc_wr;
		do begin
			@(posedge clk);
			#1;
			lat++;
			if (rdata_valid === 1'b1)
				rv_lat = lat;
		end while (cmd_ready !== 1'b1 && lat < 2000);
		`CHK(lat < 2000, 1'b1, "command never completed")
	endtask

	// Idle pins after reset
	task automatic t_idle();
		`CHK({cmd_ready, chip_sel_n, init_n, speedup_high_level, data_io_oe},
			5'h1C, "pins not idle after reset")
	endtask

	// Single write, then read back with fixed latency
	task automatic t_write_read();
		run(OP_WRITE, 23'h000012, 8'h5A, 1'b0);
		`CHK(n_wr - w0, 1, "single write not one strobe")
		run(OP_READ, 23'h000012, 8'h00, 1'b0);
		`CHK(rdata, 8'h5A, "read data wrong")
		`CHK(rv_lat, `ACCESS_CYC + 2, "read latency wrong")
	endtask

	// Two-cycle program, with and without the speedup level
	task automatic t_prog2();
		run(OP_PROG2, 23'h000034, 8'hC3, 1'b1);
		`CHK(n_wr - w0, 2, "program not two strobes")
		`CHK(n_acc_wr - a0, 2, "speedup level not held")
		`CHK(lat, 28, "program length wrong")
		`CHK(speedup_high_level, 1'b0, "speedup left high")
		run(OP_PROG2, 23'h000035, 8'h3C, 1'b0);
		`CHK(n_acc_wr - a0, 0, "speedup without request")
		run(OP_READ, 23'h000034, 8'h00, 1'b0);
		`CHK(rdata, 8'hC3, "programmed byte wrong")
	endtask

	// Sector field follows the upper address bits
	task automatic t_sector();
		logic [22:0] tbl [4];
		tbl = '{23'h00FFFF, 23'h010000, 23'h1AFFFF, 23'h7F0000};
		foreach (tbl[i]) begin
			@(posedge clk);
			cmd_addr <= tbl[i];
			@(posedge clk);
			@(posedge clk);
			#1;
			`CHK(sector_select_bits, tbl[i][22:16], "sector field wrong")
		end
	endtask

	// Reset during a busy write, then reset while idle
	task automatic t_reset();
		run(OP_WRITE, 23'h000050, 8'h77, 1'b0);
		run(OP_RESET, 23'h000000, 8'h00, 1'b0);
		`CHK(op_aborted, 1'b1, "busy reset not flagged")
		`CHK(lat > 90, 1'b1, "ready before device ready")
		run(OP_READ, 23'h000012, 8'h00, 1'b0);
		`CHK(rdata, 8'h5A, "array read after reset")
		`CHK(op_aborted, 1'b0, "flag not cleared")
		run(OP_RESET, 23'h000000, 8'h00, 1'b0);
		`CHK(op_aborted, 1'b0, "idle reset flagged")
		`CHK(lat < 75, 1'b1, "idle reset too long")
	endtask

	////////////////////////////////////////
	// Verdict and end of run
	task automatic end_sim();
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		t_idle();
		t_write_read();
		t_prog2();
		t_sector();
		t_reset();
		end_sim();
	end

	// Hang guard, well beyond the expected few hundred cycles
	initial begin
		#200000;
		n_fail++;
		end_sim();
	end
endmodule
